// [src/hss_status_bank.sv]
// Purpose: read-only status response bank of a high-side switch
// Assumes: monitor inputs are on clk, pins and link are asynchronous
// Notes: a word's sticky flags clear once that word has been sent, except the undervoltage copy in the identification word
// Notes on behaviour
// - 16-bit word, address nibble on top
// - reset clears all but summary, cleared flag
// - undocumented bits default to inactive
// - channel summary bits OR all channel faults
// - bit 8 ORs every open-load indication
// - bit 9 ORs overcurrents and thermal shutdowns
// - bit 10 ORs supply, pump, clock, cleared, test
// - channel word bit 0 off-state open load
// - channel word bit 1 on-state open load
// - channel word bit 5 thermal warning
// - bit 6 shutdown, cause code bits 4-2
// - device word bit 0 deglitched fallback level
// - device word serial, supply, test flags
// - pin word live half-supply compares
// - pin word deglitched direct input levels
// - pin word bit 9 ORs input-on signals
// - identification type, family, revision, undervoltage
`timescale 1ns/1ps
module hss_status_bank
  import hss_pkg::*;
#(
  parameter int FILT_CYCLES = FILT_CYC,
  parameter logic [TYPE_W-1:0] ID_TYPE = ID_TYPE_DEF,
  parameter logic [FAM_W-1:0] ID_FAM = ID_FAM_DEF,
  parameter logic [REV_W-1:0] ID_REV = ID_REV_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  input wire logic fail_state_flag,
  input wire logic pump_fault,
  input wire logic pwm_clock_fault,
  input wire logic supply_low,
  input wire logic supply_high,
  input wire logic test_active,
  input wire logic [NCH-1:0][OC_W-1:0] overcurrent_cause_code,
  input wire logic [NCH-1:0] thermal_warning,
  input wire logic [NCH-1:0] thermal_shutdown,
  input wire logic [NCH-1:0] open_load_active,
  input wire logic [NCH-1:0] open_load_idle,
  input wire logic fallback_pin,
  input wire logic [NIN-1:0] direct_control_input,
  input wire logic [NCH-1:0] output_half_supply_compare,
  input wire logic [NIN-1:0] input_channel_on,
  output hss_word_t rx_word,
  output logic rx_valid
);
  localparam int NFILT = NIN + 1;
  localparam int FCW = $clog2(FILT_CYCLES + 1);
  localparam int NSYNC = NFILT + NCH + 2;
  localparam logic [FCW-1:0] FILT_LAST = FCW'(FILT_CYCLES - 1);

  typedef struct packed {
    logic [NCH-1:0][OC_W-1:0] oc;
    logic [NCH-1:0] warn;
    logic [NCH-1:0] shut;
    logic [NCH-1:0] ol_on;
    logic [NCH-1:0] ol_off;
    logic uv;
    logic ov;
    logic pump;
    logic pwm_clock_fault_flag;
    logic tm;
    logic serial_fault_flag;
    logic regs_cleared_flag;
    logic [NFILT-1:0] lvl;
    logic [NFILT-1:0][FCW-1:0] fcnt;
    logic tgl_d;
    logic cs_d;
    logic got;
    logic [ADDR_W-1:0] addr;
    hss_word_t tx;
    hss_word_t rx;
    logic rx_v;
  } hss_bank_s;

  hss_bank_s s_r;
  hss_bank_s s_nxt;
  hss_word_t link_rx;
  logic link_tgl;
  logic [NSYNC-1:0] sync_in;
  logic [NSYNC-1:0] sync_out;
  logic [NFILT-1:0] raw_lvl;
  logic [NCH-1:0] cmp_lvl;
  logic cs_s;
  logic tgl_s;
  logic frame_end;
  logic word_done;
  logic [ADDR_W-1:0] sent_addr;
  logic device_summary_flag;
  logic ovl;
  logic global_open_load_flag;
  logic [NCH-1:0] qs;
  hss_data_t ch_data [NCH];
  hss_data_t data_sel;
  // per-word response data
  hss_data_t common_data;
  hss_data_t quick_data;
  hss_data_t dev_data;
  hss_data_t pin_data;
  hss_data_t id_data;
  // read strobes and frame faults
  logic rd_quick;
  logic rd_dev;
  logic [NCH-1:0] rd_ch;
  logic frame_short;

  // serial shifter on the link clock
  hss_spi_link u_link (
    .sclk(sclk),
    .rst(rst),
    .cs_n(cs_n),
    .si(si),
    .tx_word(s_r.tx),
    .so(so),
    .so_oe(so_oe),
    .rx_word(link_rx),
    .done_tgl(link_tgl)
  );

  // pins, select and word toggle into the clk domain
  assign sync_in = {cs_n, link_tgl, output_half_supply_compare, direct_control_input,
                    fallback_pin};
  hss_sync #(
    .W(NSYNC),
    .INIT({1'b1, {(NSYNC - 1){1'b0}}})
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .d(sync_in),
    .q(sync_out)
  );
  assign raw_lvl = sync_out[NFILT-1:0];
  assign cmp_lvl = sync_out[NFILT+NCH-1:NFILT];
  assign tgl_s = sync_out[NSYNC-2];
  assign cs_s = sync_out[NSYNC-1];

  // frame and word events seen from the clk side
  assign frame_end = cs_s & ~s_r.cs_d;
  assign word_done = tgl_s ^ s_r.tgl_d;
  assign sent_addr = s_r.tx[WORD_W-1:DATA_W];

  // a word counts as read once its last bit has been taken
  assign rd_quick = word_done && sent_addr == ADR_QUICK;
  assign rd_dev = word_done && sent_addr == ADR_DEV;
  // word toggle and deselect may land on one edge, that frame was whole
  assign frame_short = frame_end & ~s_r.got & ~word_done;

  // global summary flags
  assign device_summary_flag = s_r.uv | s_r.ov | s_r.pump | s_r.regs_cleared_flag | s_r.pwm_clock_fault_flag | s_r.tm;
  assign global_open_load_flag = (|s_r.ol_on) | (|s_r.ol_off);
  always_comb begin
    ovl = |s_r.shut;
    for (int i = 0; i < NCH; i++) begin
      ovl = ovl | (|s_r.oc[i]);
    end
  end

  genvar g;
  // per-channel summary bit and channel word
  for (g = 0; g < NCH; g++) begin : g_ch
    assign qs[g] = (|s_r.oc[g]) | s_r.warn[g] | s_r.shut[g] | s_r.ol_on[g]
                   | s_r.ol_off[g];
    assign rd_ch[g] = word_done && sent_addr == ADR_CH1 + ADDR_W'(g);
    always_comb begin
      ch_data[g] = '0;
      ch_data[g][B_FAIL] = fail_state_flag;
      ch_data[g][B_DSF] = device_summary_flag;
      ch_data[g][B_OVL] = ovl;
      ch_data[g][B_OL] = global_open_load_flag;
      ch_data[g][B_OTS] = s_r.shut[g];
      ch_data[g][B_OTW] = s_r.warn[g];
      ch_data[g][B_OC+:OC_W] = s_r.oc[g];
      ch_data[g][B_OLON] = s_r.ol_on[g];
      ch_data[g][B_OLOFF] = s_r.ol_off[g];
    end
  end

  // flags shared by words one to seven
  always_comb begin
    common_data = '0;
    common_data[B_FAIL] = fail_state_flag;
    common_data[B_DSF] = device_summary_flag;
    common_data[B_OVL] = ovl;
    common_data[B_OL] = global_open_load_flag;
  end

  // quick summary word
  always_comb begin
    quick_data = common_data;
    quick_data[B_PUMP] = s_r.pump;
    quick_data[B_RCF] = s_r.regs_cleared_flag;
    quick_data[B_PWM_CLOCK_FAULT_FLAG] = s_r.pwm_clock_fault_flag;
    quick_data[B_QS+:NCH] = qs;
  end

  // device health word, fallback level deglitched
  always_comb begin
    dev_data = common_data;
    dev_data[B_TM] = s_r.tm;
    dev_data[B_OV] = s_r.ov;
    dev_data[B_UV] = s_r.uv;
    dev_data[B_SERIAL_FAULT_FLAG] = s_r.serial_fault_flag;
    dev_data[B_LIMP] = s_r.lvl[0];
  end

  // pin levels word, no summary flags here
  always_comb begin
    pin_data = '0;
    pin_data[B_FAIL] = fail_state_flag;
    pin_data[B_TOG] = |input_channel_on;
    pin_data[B_IN+:NIN] = s_r.lvl[NFILT-1:1];
    pin_data[B_OUT+:NCH] = cmp_lvl;
  end

  // identification word, fixed fields and supply copy
  always_comb begin
    id_data = '0;
    id_data[B_FAIL] = fail_state_flag;
    id_data[B_IDUV] = s_r.uv;
    id_data[B_REV+:REV_W] = ID_REV;
    id_data[B_FAM+:FAM_W] = ID_FAM;
    id_data[B_TYPE+:TYPE_W] = ID_TYPE;
  end

  // response data for the address taken from the last frame
  always_comb begin
    data_sel = '0;
    if (s_r.addr == ADR_QUICK) begin
      data_sel = quick_data;
    end
    for (int i = 0; i < NCH; i++) begin
      if (s_r.addr == ADR_CH1 + ADDR_W'(i)) begin
        data_sel = ch_data[i];
      end
    end
    if (s_r.addr == ADR_DEV) begin
      data_sel = dev_data;
    end
    if (s_r.addr == ADR_PINS) begin
      data_sel = pin_data;
    end
    if (s_r.addr == ADR_ID) begin
      data_sel = id_data;
    end
  end

  // next state of the whole bank
  always_comb begin
    s_nxt = s_r;
    s_nxt.rx_v = 1'b0;
    s_nxt.tgl_d = tgl_s;
    s_nxt.cs_d = cs_s;

    // sticky channel flags, cleared only where the sent word showed them
    for (int i = 0; i < NCH; i++) begin
      s_nxt.warn[i] = (s_r.warn[i] & ~(rd_ch[i] & s_r.tx[B_OTW])) | thermal_warning[i];
      s_nxt.shut[i] = (s_r.shut[i] & ~(rd_ch[i] & s_r.tx[B_OTS])) | thermal_shutdown[i];
      s_nxt.ol_on[i] = (s_r.ol_on[i] & ~(rd_ch[i] & s_r.tx[B_OLON])) | open_load_active[i];
      s_nxt.ol_off[i] = (s_r.ol_off[i] & ~(rd_ch[i] & s_r.tx[B_OLOFF])) | open_load_idle[i];
      // first cause code is held until reported
      if (rd_ch[i] && s_r.tx[B_OC+:OC_W] == s_r.oc[i]) begin
        s_nxt.oc[i] = '0;
      end
      if (overcurrent_cause_code[i] != '0 && s_nxt.oc[i] == '0) begin
        s_nxt.oc[i] = overcurrent_cause_code[i];
      end
    end

    // sticky quick word flags, a new event wins over the clear
    s_nxt.pump = (s_r.pump & ~(rd_quick & s_r.tx[B_PUMP])) | pump_fault;
    s_nxt.pwm_clock_fault_flag = (s_r.pwm_clock_fault_flag & ~(rd_quick & s_r.tx[B_PWM_CLOCK_FAULT_FLAG])) | pwm_clock_fault;
    s_nxt.regs_cleared_flag = s_r.regs_cleared_flag & ~(rd_quick & s_r.tx[B_RCF]);
    // sticky device health flags, cleared by a read of word seven
    s_nxt.uv = (s_r.uv & ~(rd_dev & s_r.tx[B_UV])) | supply_low;
    s_nxt.ov = (s_r.ov & ~(rd_dev & s_r.tx[B_OV])) | supply_high;
    s_nxt.tm = (s_r.tm & ~(rd_dev & s_r.tx[B_TM])) | test_active;
    // a frame closed before a whole word is a serial fault
    s_nxt.serial_fault_flag = (s_r.serial_fault_flag & ~(rd_dev & s_r.tx[B_SERIAL_FAULT_FLAG])) | frame_short;

    // deglitch: level follows the pin once stable for the filter time
    for (int i = 0; i < NFILT; i++) begin
      if (raw_lvl[i] == s_r.lvl[i]) begin
        s_nxt.fcnt[i] = '0;
      end else if (s_r.fcnt[i] == FILT_LAST) begin
        s_nxt.fcnt[i] = '0;
        s_nxt.lvl[i] = raw_lvl[i];
      end else begin
        s_nxt.fcnt[i] = s_r.fcnt[i] + FCW'(1);
      end
    end

    // a finished word hands its address to the next response
    if (word_done) begin
      s_nxt.rx = link_rx;
      s_nxt.rx_v = 1'b1;
      s_nxt.got = 1'b1;
      s_nxt.addr = link_rx[WORD_W-1:DATA_W];
    end
    if (frame_end) begin
      s_nxt.got = 1'b0;
    end

    // response word follows live state only while deselected
    if (cs_s) begin
      s_nxt.tx = {s_nxt.addr, data_sel};
    end
  end

  // one register for the whole bank
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.regs_cleared_flag <= RST_RCF;
      s_r.cs_d <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rx_word = s_r.rx;
  assign rx_valid = s_r.rx_v;
endmodule : hss_status_bank

// [src/hss_pkg.sv]
// Purpose: shared constants for the status readback bank
// Assumes: 16-bit frames, 4-bit address nibble, 12 data bits
// Notes: bit positions index the 12-bit data field of a response
package hss_pkg;
  localparam int NCH = 5;
  localparam int NIN = 4;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 12;
  localparam int OC_W = 3;
  localparam int CLK_MHZ = 125;
  // deglitch hold time of the pin filters, least time
  localparam int FILT_NS = 1000;
  localparam int FILT_CYC = (FILT_NS * CLK_MHZ + 999) / 1000;

  // response addresses
  localparam logic [ADDR_W-1:0] ADR_QUICK = 4'h1;
  localparam logic [ADDR_W-1:0] ADR_CH1 = 4'h2;
  localparam logic [ADDR_W-1:0] ADR_DEV = 4'h7;
  localparam logic [ADDR_W-1:0] ADR_PINS = 4'h8;
  localparam logic [ADDR_W-1:0] ADR_ID = 4'h9;
  localparam logic [ADDR_W-1:0] ADR_TEST = 4'hf;

  // fields common to words one to seven
  localparam int B_FAIL = 11;
  localparam int B_DSF = 10;
  localparam int B_OVL = 9;
  localparam int B_OL = 8;
  // quick summary word
  localparam int B_PUMP = 7;
  localparam int B_RCF = 6;
  localparam int B_PWM_CLOCK_FAULT_FLAG = 5;
  localparam int B_QS = 0;
  // channel words
  localparam int B_OLOFF = 0;
  localparam int B_OLON = 1;
  localparam int B_OC = 2;
  localparam int B_OTW = 5;
  localparam int B_OTS = 6;
  // device health word
  localparam int B_LIMP = 0;
  localparam int B_SERIAL_FAULT_FLAG = 1;
  localparam int B_UV = 2;
  localparam int B_OV = 3;
  localparam int B_TM = 4;
  // pin levels word
  localparam int B_OUT = 0;
  localparam int B_IN = 5;
  localparam int B_TOG = 9;
  // identification word
  localparam int B_TYPE = 0;
  localparam int B_FAM = 3;
  localparam int B_REV = 5;
  localparam int B_IDUV = 10;
  localparam int TYPE_W = 3;
  localparam int FAM_W = 2;
  localparam int REV_W = 3;

  // reset values of the sticky flags
  localparam logic RST_RCF = 1'b1;
  localparam logic RST_FLAG = 1'b0;
  // identification defaults, values arbitrary
  localparam logic [TYPE_W-1:0] ID_TYPE_DEF = 3'h7;
  localparam logic [FAM_W-1:0] ID_FAM_DEF = 2'h1;
  localparam logic [REV_W-1:0] ID_REV_DEF = 3'h1;

  typedef logic [WORD_W-1:0] hss_word_t;
  typedef logic [DATA_W-1:0] hss_data_t;
endpackage : hss_pkg

// [src/hss_sync.sv]
// Purpose: two-flop synchroniser for a group of unrelated levels
// Assumes: each bit is independent, no bus coherency needed
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module hss_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  genvar g;
  // one two-stage chain per bit
  for (g = 0; g < W; g++) begin : g_bit
    typedef struct packed {
      logic meta;
      logic stable;
    } hss_sync_s;
    hss_sync_s s_r;
    hss_sync_s s_nxt;
    always_comb begin
      s_nxt.meta = d[g];
      s_nxt.stable = s_r.meta;
    end
    always_ff @(posedge clk) begin
      if (rst) begin
        s_r <= '{meta: INIT[g], stable: INIT[g]};
      end else begin
        s_r <= s_nxt;
      end
    end
    assign q[g] = s_r.stable;
  end
endmodule : hss_sync

// [src/hss_spi_link.sv]
// Purpose: serial shifter on the link clock
// Assumes: master drives input on rising edge, samples output on rising edge
// Notes: frame counter is cleared by the select line itself
`timescale 1ns/1ps
module hss_spi_link
  import hss_pkg::*;
(
  input wire logic sclk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic si,
  input wire hss_word_t tx_word,
  output logic so,
  output logic so_oe,
  output hss_word_t rx_word,
  output logic done_tgl
);
  typedef struct packed {
    logic [ADDR_W-1:0] cnt;
    logic [WORD_W-2:0] sh;
  } hss_frm_s;
  typedef struct packed {
    hss_word_t rx;
    logic tgl;
  } hss_wrd_s;
  hss_frm_s f_r;
  hss_frm_s f_nxt;
  hss_wrd_s w_r;
  hss_wrd_s w_nxt;
  logic last;

  // bit counter wraps every sixteen edges
  assign last = (f_r.cnt == 4'hf);
  always_comb begin
    f_nxt.cnt = f_r.cnt + 4'h1;
    f_nxt.sh = {f_r.sh[WORD_W-3:0], si};
    w_nxt = w_r;
    if (last) begin
      w_nxt.rx = {f_r.sh, si};
      w_nxt.tgl = ~w_r.tgl;
    end
  end

  // deselect ends the frame, no link edge needed
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      f_r <= '0;
    end else begin
      f_r <= f_nxt;
    end
  end

  // finished words survive deselect
  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      w_r <= '0;
    end else begin
      w_r <= w_nxt;
    end
  end

  // msb first, word held stable by the core domain during the frame
  assign so = tx_word[4'hf - f_r.cnt];
  assign so_oe = ~cs_n;
  assign rx_word = w_r.rx;
  assign done_tgl = w_r.tgl;
endmodule : hss_spi_link

// [tb/hss_status_bank_checker.sv]
// Purpose: port checker for the status readback bank
// Assumes: master shifts si on sclk rise, device shifts on sclk fall
// Notes: frame decode helpers run on the link clock
`timescale 1ns/1ps
module hss_status_bank_checker
  import hss_pkg::*;
#(
  parameter logic [TYPE_W-1:0] ID_TYPE = ID_TYPE_DEF,
  parameter logic [FAM_W-1:0] ID_FAM = ID_FAM_DEF,
  parameter logic [REV_W-1:0] ID_REV = ID_REV_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe,
  input wire hss_word_t rx_word,
  input wire logic rx_valid
);
  logic [3:0] cnt_r;
  logic [14:0] sh_r;
  logic [3:0] adr_r;
  hss_word_t wd_r;
  logic tg_r;
  logic t1_r;
  logic t2_r;
  logic res_w;
  logic [7:0] id_w;
  // bit count and shifter of the running frame
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
      sh_r <= {sh_r[13:0], si};
    end
  end
  // last full word, its address and a done toggle
  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      adr_r <= '0;
      tg_r <= 1'b0;
    end else if (!cs_n && cnt_r == 4'hf) begin
      adr_r <= sh_r[14:11];
      wd_r <= {sh_r, si};
      tg_r <= ~tg_r;
    end
  end
  // done toggle brought to the core clock
  always_ff @(posedge clk) begin
    t1_r <= tg_r;
    t2_r <= t1_r;
  end
  assign id_w = {ID_REV, ID_FAM, ID_TYPE};
  // reserved positions by answered address and bit count
  always_comb begin
    res_w = 1'b0;
    if (adr_r inside {[ADR_CH1:4'h6]}) res_w = (cnt_r == 4'h8);
    if (adr_r == ADR_DEV) res_w = cnt_r inside {[4'h8:4'ha]};
    if (adr_r == ADR_PINS) res_w = (cnt_r == 4'h5);
    if (adr_r == ADR_ID) res_w = cnt_r inside {4'h6, 4'h7};
  end
  property p_oe;
    @(posedge clk) disable iff (rst) so_oe == !cs_n;
  endproperty
  a_oe: assert property (p_oe) else $error("so enable not tied to select");
  property p_echo;
    @(posedge sclk) disable iff (rst) (!cs_n && cnt_r < 4'h4) |-> so == adr_r[3 - cnt_r];
  endproperty
  a_echo: assert property (p_echo) else $error("address nibble not echoed");
  property p_rxw;
    @(posedge clk) disable iff (rst) rx_valid |-> rx_word == wd_r;
  endproperty
  a_rxw: assert property (p_rxw) else $error("received word differs from line");
  property p_bound;
    @(posedge clk) disable iff (rst) (t1_r != t2_r) |-> ##[0:6] rx_valid;
  endproperty
  a_bound: assert property (p_bound) else $error("received word not flagged");
  property p_pulse;
    @(posedge clk) disable iff (rst) rx_valid |=> !rx_valid [*4];
  endproperty
  a_pulse: assert property (p_pulse) else $error("receive flag too long");
  property p_rst;
    @(posedge clk) disable iff (rst) $fell(rst) |-> !rx_valid [*4];
  endproperty
  a_rst: assert property (p_rst) else $error("receive flag after reset");
  property p_res;
    @(posedge sclk) disable iff (rst) (!cs_n && res_w) |-> !so;
  endproperty
  a_res: assert property (p_res) else $error("reserved bit set");
  property p_id;
    @(posedge sclk) disable iff (rst)
      (!cs_n && adr_r == ADR_ID && cnt_r >= 4'h8) |-> so == id_w[15 - cnt_r];
  endproperty
  a_id: assert property (p_id) else $error("identification field wrong");
  property p_unused;
    @(posedge sclk) disable iff (rst)
      (!cs_n && cnt_r >= 4'h4 && (adr_r == 4'h0 || adr_r > ADR_ID)) |-> !so;
  endproperty
  a_unused: assert property (p_unused) else $error("unused word not zero");
endmodule : hss_status_bank_checker

bind hss_status_bank hss_status_bank_checker #(
  .ID_TYPE(ID_TYPE), .ID_FAM(ID_FAM), .ID_REV(ID_REV)
) u_chk (
  .clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so),
  .so_oe(so_oe), .rx_word(rx_word), .rx_valid(rx_valid)
);

// [tb/hss_spi_host.sv]
// Purpose: serial master model for the status bank
// Assumes: link clock idles low and stands still between frames
// Notes: a completed word is offered with a short got_v pulse
`timescale 1ns/1ps
module hss_spi_host
  import hss_pkg::*;
(
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so,
  input wire logic so_oe,
  output hss_word_t got_word,
  output logic got_v
);
  // idle levels
  initial begin
    sclk <= 1'b0; // late update so the link counters see a deselect edge
    cs_n <= 1'b1;
    si = 1'b1;
    got_v = 1'b0;
    got_word = '0;
  end
  // one frame of n bits at 6 ns, so taken on each rise
  task automatic xfer(input hss_word_t w, input int n);
    hss_word_t r;
    r = '0;
    #1.3;
    cs_n = 1'b0;
    #10;
    for (int i = 0; i < n; i++) begin
      #3 sclk = 1'b1;
      r = {r[14:0], so};
      si = w[15-i];
      #3 sclk = 1'b0;
    end
    #3 cs_n = 1'b1;
    si = ~si; // released line does not keep its value
    if (n == 16) begin
      got_word = r;
      got_v = 1'b1;
      #1 got_v = 1'b0;
    end
  endtask : xfer
endmodule : hss_spi_host

// [tb/hss_status_bank_tb_top.sv]
// Purpose: self-checking bench of the status readback bank
// Assumes: monitor levels held steady while words are read
// Notes: each read notes the word answering the address sent one frame earlier
`timescale 1ns/1ps
module hss_status_bank_tb_top
  import hss_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b0;
  logic sclk, cs_n, si, so, so_oe, rx_valid, got_v;
  hss_word_t rx_word, got_word;
  logic fail_state_flag = 0, pump_fault = 0, pwm_clock_fault = 0, fallback_pin = 0;
  logic supply_low = 0, supply_high = 0, test_active = 0;
  logic [NCH-1:0][OC_W-1:0] overcurrent_cause_code = '0;
  logic [NCH-1:0] thermal_warning = '0, thermal_shutdown = '0, open_load_active = '0;
  logic [NCH-1:0] open_load_idle = '0, output_half_supply_compare = '0;
  logic [NIN-1:0] direct_control_input = '0, input_channel_on = '0;
  int seed = 10, n_errors = 0, checks_done = 0;
  logic regs_cleared_flag = 1'b1, spf = 1'b0;
  logic [3:0] prev = 4'h0;
  logic [31:0] q_so[$];
  hss_word_t q_rx[$];
  logic [31:0] e32;
  logic [63:0] rv;

  always #4 clk = ~clk;
  hss_status_bank #(.FILT_CYCLES(4)) dut (.*);
  hss_spi_host host (.*);

  task automatic chk(input string n, input hss_word_t e, input hss_word_t g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  // expected response word from the held levels
  function automatic hss_word_t ew(input logic [3:0] a);
    hss_data_t d;
    logic [NCH-1:0] ocn;
    int i;
    for (i = 0; i < NCH; i++) ocn[i] = |overcurrent_cause_code[i];
    d = '0;
    d[B_FAIL] = fail_state_flag;
    d[B_DSF] = supply_low | supply_high | pump_fault | pwm_clock_fault | test_active | regs_cleared_flag;
    d[B_OVL] = |{ocn, thermal_shutdown};
    d[B_OL] = |{open_load_active, open_load_idle};
    if (a == ADR_QUICK) begin
      d[B_PUMP] = pump_fault;
      d[B_RCF] = regs_cleared_flag;
      d[B_PWM_CLOCK_FAULT_FLAG] = pwm_clock_fault;
      d[4:0] = ocn | thermal_warning | thermal_shutdown | open_load_active | open_load_idle;
    end else if (a >= ADR_CH1 && a < ADR_DEV) begin
      i = int'(a) - 2;
      d[7:0] = {1'b0, thermal_shutdown[i], thermal_warning[i], overcurrent_cause_code[i],
                open_load_active[i], open_load_idle[i]};
    end else if (a == ADR_DEV) begin
      d[7:0] = {3'h0, test_active, supply_high, supply_low, spf, fallback_pin};
    end else if (a == ADR_PINS) begin
      d = {fail_state_flag, 1'b0, |input_channel_on, direct_control_input,
           output_half_supply_compare};
    end else if (a == ADR_ID) begin
      d = {fail_state_flag, supply_low, 2'h0, ID_REV_DEF, ID_FAM_DEF, ID_TYPE_DEF};
    end else begin
      d = '0;
    end
    return {a, d};
  endfunction : ew

  // one frame: note answer and received word, then send
  task automatic rd(input logic [3:0] a, input hss_word_t m);
    hss_word_t w;
    w = {a, 12'($random(seed))};
    q_so.push_back({m, ew(prev)});
    q_rx.push_back(w);
    if (prev == ADR_QUICK) regs_cleared_flag = 1'b0;
    if (prev == ADR_DEV) spf = 1'b0;
    prev = a;
    host.xfer(w, 16);
    repeat (10) @(posedge clk);
  endtask : rd

  // apply all monitor levels at once and let them settle
  task automatic setin(input logic [59:0] v);
    @(posedge clk);
    {fail_state_flag, pump_fault, pwm_clock_fault, supply_low, supply_high, test_active,
     overcurrent_cause_code, thermal_warning, thermal_shutdown, open_load_active,
     open_load_idle, fallback_pin, direct_control_input, output_half_supply_compare,
     input_channel_on} <= v;
    repeat (20) @(posedge clk);
  endtask : setin

  // serial answers against the oldest note
  always @(posedge got_v) begin
    if (q_so.size() == 0) begin
      n_errors++;
      $display("wrong value so word expected none seen %h", got_word);
    end else begin
      e32 = q_so.pop_front();
      chk("so word", e32[15:0] & e32[31:16], got_word & e32[31:16]);
    end
  end

  // received words against the sent ones
  always @(posedge clk) begin
    if (rx_valid === 1'b1) begin
      if (q_rx.size() == 0) begin
        n_errors++;
        $display("wrong value rx word expected none seen %h", rx_word);
      end else begin
        chk("rx word", q_rx.pop_front(), rx_word);
      end
    end
  end

  // main sequence
  initial begin
    rst <= 1'b1; // rising edge also clears the link side
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    rd(ADR_QUICK, 16'hffff);
    rd(ADR_ID, 16'hffff);
    rd(ADR_DEV, 16'hffff);
    rd(ADR_PINS, 16'hffff);
    rd(4'hc, 16'hffff);
    rd(4'h0, 16'hffff);
    $display("test reset words done");
    host.xfer(16'h7000, 8);
    repeat (10) @(posedge clk);
    spf = 1'b1;
    rd(ADR_DEV, 16'hffff);
    rd(4'h0, 16'hffff);
    $display("test short frame done");
    repeat (20) begin
      setin('0);
      for (int a = 1; a < 8; a++) rd(4'(a), 16'h0);
      rd(4'h0, 16'h0);
      rv = {$random(seed), $random(seed)};
      setin(rv[59:0]);
      for (int a = 1; a < 10; a++) rd(4'(a), 16'hffff);
      rd(4'h0, 16'hffff);
    end
    $display("test random words done");
    chk("notes left", 16'h0, 16'(q_so.size() + q_rx.size()));
    finish_test();
  end

  // watchdog
  initial begin
    #400000;
    n_errors++;
    finish_test();
  end
endmodule : hss_status_bank_tb_top
